//--- fpp_checker.sv
// assertion checker for the flash page program sequencer
`timescale 1ns/100ps
module fpp_checker (
  input wire logic                   i_clk, i_nrst, i_psel, i_penable, i_pwrite, i_fl_ready,
  input wire logic [11:0]            i_paddr,
  input wire logic [31:0]            i_pwdata, o_prdata,
  input wire logic                   o_pready, o_pslverr, o_ram_rd, o_cpu_hold, o_fl_wr, o_fl_commit,
  input wire fpp_pkg::fpp_flash_wr_t o_fl_req
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  AST_TRIG: assert property ($rose(o_cpu_hold) |->
    $past(i_psel && i_penable && i_pwrite && i_paddr == 12'h250 && i_pwdata[7:0] == 8'h5a)) else $error("bad start");
  AST_FIRST: assert property ($rose(o_cpu_hold) |-> o_ram_rd ##2 (o_fl_wr && o_fl_req.addr[4:0] == 5'h00))
    else $error("first byte not at page start");
  AST_STABLE: assert property (o_fl_wr && !i_fl_ready |=> o_fl_wr && $stable(o_fl_req)) else $error("write dropped");
  AST_HELD: assert property (o_fl_wr || o_ram_rd || o_fl_commit |-> o_cpu_hold) else $error("cpu not held");
  AST_COMMIT: assert property (o_fl_commit |=> !o_fl_commit && !o_fl_wr) else $error("commit too long");
  AST_RAM: assert property (o_ram_rd |=> !o_ram_rd ##1 o_fl_wr) else $error("ram byte not forwarded");
  AST_ERR: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0) else $error("bad error answer");
  AST_RDY: assert property (o_pready |-> o_prdata[31:8] == 24'h0 ##1 !o_pready) else $error("bad ready");
endmodule

//--- fpp_flash_model.sv
// flash array model: byte writes with optional stalls, commit with busy delay
`timescale 1ns/100ps
module fpp_flash_model (
  input  wire logic                   i_clk,
  input  wire logic                   i_slow,
  input  wire logic                   i_fl_wr,
  input  wire fpp_pkg::fpp_flash_wr_t i_fl_req,
  input  wire logic                   i_fl_commit,
  output logic                        o_fl_ready,
  output logic                        o_fl_done
);
  import fpp_pkg::*;
  logic [7:0] mem [0:16383];
  logic [3:0] busy_q = 4'h0;
  initial o_fl_ready = 1'b0;
  initial o_fl_done = 1'b0;
  always @(posedge i_clk) begin
    o_fl_ready <= i_slow ? ~o_fl_ready : 1'b1;
    if (i_fl_wr && o_fl_ready) mem[i_fl_req.addr[13:0]] <= i_fl_req.data;
    busy_q <= i_fl_commit ? 4'h6 : busy_q - 4'(busy_q != 0);
    o_fl_done <= busy_q == 4'h1;
  end
endmodule

//--- fpp_pkg.sv
// constants and carrier types for the flash page program sequencer
package fpp_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CMD_LOW   = 10'h094;
  localparam logic [9:0] IDX_PAGE_LOW  = 10'h095;
  localparam logic [9:0] IDX_PAGE_HIGH = 10'h096;
  localparam logic [9:0] IDX_BUF_START = 10'h097;
  localparam logic [9:0] IDX_STATUS    = 10'h098;
  // field positions
  localparam int PAGE_LOW_LSB  = 5;
  localparam int CMD_NIB_MSB   = 3;
  localparam int STAT_BUSY_BIT = 0;
  // reset values and codes
  localparam logic [7:0] BUF_START_RST = 8'h00;
  localparam logic [7:0] PAGE_HIGH_RST = 8'h00;
  localparam logic [2:0] PAGE_LOW_RST  = 3'h0;
  localparam logic [3:0] CMD_NIB_RST   = 4'h0;
  localparam logic [3:0] CMD_ENABLE    = 4'ha;
  localparam logic [7:0] CMD_START     = 8'h5a;
  // flash geometry
  localparam int PAGE_BYTES = 32;
  localparam int PAGE_COUNT = 512;
  localparam int OFS_BITS   = 5;

  typedef enum {ST_IDLE, ST_READ, ST_LOAD, ST_WRITE, ST_COMMIT, ST_WAIT} fpp_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } fpp_flash_wr_t;
endpackage

//--- fpp_seq.sv
// flash page program sequencer with apb register access
// Behaviour
// - flash is 512 pages of 32 bytes; only whole pages are written
// - page data comes from 32 consecutive internal data ram bytes
// - 8-bit read/write buffer start register, reset to zero
// - page address bits 15..8 in high register, 7..5 in low register
// - flash address bits 4..0 are zero at every page start
// - programming enabled only while the command nibble holds 0xa
// - writing 0x5a to command byte while enabled starts the program
// - once triggered, 32 bytes from buffer start copy into the page
`timescale 1ns/100ps
module fpp_seq (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_nrst,
  // apb slave
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [11:0]            i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic                        o_pready,
  output logic [31:0]                 o_prdata,
  output logic                        o_pslverr,
  // internal data ram read port, data one cycle after the request
  output logic                        o_ram_rd,
  output logic [7:0]                  o_ram_addr,
  input  wire logic [7:0]             i_ram_rdata,
  // flash array write port
  output logic                        o_fl_wr,
  output fpp_pkg::fpp_flash_wr_t      o_fl_req,
  input  wire logic                   i_fl_ready,
  output logic                        o_fl_commit,
  input  wire logic                   i_fl_done,
  // cpu stall
  output logic                        o_cpu_hold
);
  import fpp_pkg::*;

  // last byte offset of a page
  localparam logic [OFS_BITS-1:0] OFS_LAST = OFS_BITS'(PAGE_BYTES - 1);

  // the offset counter must span exactly one page
  if ((1 << OFS_BITS) != PAGE_BYTES) begin
    $error("offset width does not match the page size");
  end

  // the flash port carries a 16-bit byte address
  if (PAGE_BYTES * PAGE_COUNT > 65536) begin
    $error("flash does not fit a 16-bit byte address");
  end

  // the latched page is 11 bits above the offset
  if (OFS_BITS + 11 != 16) begin
    $error("page latch and offset do not fill the flash address");
  end

  // one register select
  function automatic logic reg_hit(input logic [9:0] idx, input logic [9:0] target);
    reg_hit = idx == target;
  endfunction

  // ram byte for a page offset; wraps inside the 256-byte ram
  function automatic logic [7:0] ram_byte_addr(input logic [7:0] base, input logic [OFS_BITS-1:0] ofs);
    ram_byte_addr = 8'(base + 8'(ofs));
  endfunction

  // flash byte: latched page above, byte offset below
  function automatic logic [15:0] flash_byte_addr(input logic [10:0] page, input logic [OFS_BITS-1:0] ofs);
    flash_byte_addr = {page, ofs};
  endfunction

  // sequencer state
  fpp_state_t            state_q;
  fpp_state_t            state_d;
  // software visible registers
  logic [7:0]            buf_start_q;
  logic [7:0]            page_high_q;
  logic [2:0]            page_low_q;
  logic [3:0]            cmd_nib_q;
  // run copies, frozen at the trigger so later writes cannot move a running page
  logic [7:0]            run_base_q;
  logic [10:0]           run_page_q;
  logic [OFS_BITS-1:0]   ofs_q;

  // bus decode
  wire logic [9:0]       idx      = i_paddr[11:2];
  wire logic             setup    = i_psel & ~i_penable;
  wire logic             access   = i_psel & i_penable & o_pready;
  wire logic             wr_acc   = access & i_pwrite & ~o_pslverr;
  wire logic             hit_cl   = reg_hit(idx, IDX_CMD_LOW);
  wire logic             hit_pl   = reg_hit(idx, IDX_PAGE_LOW);
  wire logic             hit_ph   = reg_hit(idx, IDX_PAGE_HIGH);
  wire logic             hit_bs   = reg_hit(idx, IDX_BUF_START);
  wire logic             hit_st   = reg_hit(idx, IDX_STATUS);
  wire logic             mapped   = hit_cl | hit_pl | hit_ph | hit_bs | hit_st;
  wire logic             wr_cl    = wr_acc & hit_cl;
  wire logic             wr_pl    = wr_acc & hit_pl;
  wire logic             wr_ph    = wr_acc & hit_ph;
  wire logic             wr_bs    = wr_acc & hit_bs;
  wire logic [7:0]       wr_byte  = i_pwdata[7:0];

  // command decode
  wire logic             busy     = state_q != ST_IDLE;
  wire logic             enabled  = cmd_nib_q == CMD_ENABLE;
  wire logic             start_cd = wr_byte == CMD_START;
  // a start while busy is dropped; the cpu is stalled then anyway
  wire logic             trigger  = wr_cl & start_cd & enabled & ~busy;

  // sequencer step decode
  wire logic             last     = ofs_q == OFS_LAST;
  wire logic             in_load  = state_q == ST_LOAD;
  wire logic             accepted = (state_q == ST_WRITE) & i_fl_ready;
  wire logic             go_read  = state_d == ST_READ;
  wire logic             go_cmt   = state_d == ST_COMMIT;
  wire logic             go_idle  = state_d == ST_IDLE;

  // read data; command byte and nibble read as zero, reserved bit 4 too
  wire logic [7:0]       rd_pl    = {page_low_q, 5'h00};
  wire logic [7:0]       rd_st    = {7'h00, busy};
  wire logic [7:0]       rd_byte  = hit_pl ? rd_pl :
                                    hit_ph ? page_high_q :
                                    hit_bs ? buf_start_q :
                                    hit_st ? rd_st : 8'h00;
  wire logic [31:0]      rd_word  = {24'h00_0000, rd_byte};

  // bus answer next values; data is zero outside the access cycle
  wire logic             pready_d  = setup;
  wire logic [31:0]      prdata_d  = setup ? rd_word : 32'h0000_0000;
  wire logic             pslverr_d = setup & ~mapped;

  // register next values
  wire logic [7:0]       buf_start_d = wr_bs ? wr_byte : buf_start_q;
  wire logic [7:0]       page_high_d = wr_ph ? wr_byte : page_high_q;
  wire logic [2:0]       page_low_d  = wr_pl ? wr_byte[7:PAGE_LOW_LSB] : page_low_q;
  // trigger disarms so a stray second start byte cannot retrigger
  wire logic [3:0]       cmd_nib_d   = wr_pl   ? wr_byte[CMD_NIB_MSB:0] :
                                       trigger ? CMD_NIB_RST : cmd_nib_q;
  wire logic [7:0]       run_base_d  = trigger ? buf_start_q : run_base_q;
  wire logic [10:0]      run_page_d  = trigger ? {page_high_q, page_low_q} : run_page_q;
  wire logic [OFS_BITS-1:0] ofs_next = OFS_BITS'(ofs_q + 1'b1);
  wire logic [OFS_BITS-1:0] ofs_d    = trigger ? '0 : accepted ? ofs_next : ofs_q;
  // the next read follows the offset that is being counted at the same edge
  wire logic [7:0]       ram_addr_d  = trigger ? ram_byte_addr(buf_start_q, '0) :
                                       ram_byte_addr(run_base_q, ofs_next);
  wire logic             fl_wr_d     = in_load | (o_fl_wr & ~accepted);
  wire logic [15:0]      fl_addr_d   = in_load ? flash_byte_addr(run_page_q, ofs_q) : o_fl_req.addr;
  wire logic [7:0]       fl_data_d   = in_load ? i_ram_rdata : o_fl_req.data;
  wire logic             hold_d      = ~go_idle;

  // sequencer next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (trigger)
          state_d = ST_READ;
      end
      ST_READ: begin
        state_d = ST_LOAD;
      end
      ST_LOAD: begin
        state_d = ST_WRITE;
      end
      ST_WRITE: begin
        if (i_fl_ready)
          state_d = last ? ST_COMMIT : ST_READ;
      end
      ST_COMMIT: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (i_fl_done)
          state_d = ST_IDLE;
      end
    endcase
  end

  // apb ready: the cycle after setup, zero wait states
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= pready_d;
    end
  end

  // apb read data
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_prdata <= 32'h0000_0000;
    end else begin
      o_prdata <= prdata_d;
    end
  end

  // apb error for an unmapped index
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= pslverr_d;
    end
  end

  // buffer start
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      buf_start_q <= BUF_START_RST;
    end else begin
      buf_start_q <= buf_start_d;
    end
  end

  // page address high byte
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      page_high_q <= PAGE_HIGH_RST;
    end else begin
      page_high_q <= page_high_d;
    end
  end

  // page address low bits
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      page_low_q <= PAGE_LOW_RST;
    end else begin
      page_low_q <= page_low_d;
    end
  end

  // enable nibble
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cmd_nib_q <= CMD_NIB_RST;
    end else begin
      cmd_nib_q <= cmd_nib_d;
    end
  end

  // sequencer state
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // run buffer base
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      run_base_q <= 8'h00;
    end else begin
      run_base_q <= run_base_d;
    end
  end

  // run page
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      run_page_q <= 11'h000;
    end else begin
      run_page_q <= run_page_d;
    end
  end

  // byte offset within the page
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ofs_q <= '0;
    end else begin
      ofs_q <= ofs_d;
    end
  end

  // ram read strobe
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_ram_rd <= 1'b0;
    end else begin
      o_ram_rd <= go_read;
    end
  end

  // ram address, moved only when a read is issued
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_ram_addr <= 8'h00;
    end else if (go_read) begin
      o_ram_addr <= ram_addr_d;
    end
  end

  // flash byte write request, held until taken
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_fl_wr <= 1'b0;
    end else begin
      o_fl_wr <= fl_wr_d;
    end
  end

  // flash byte address and data
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_fl_req <= '0;
    end else begin
      o_fl_req <= {fl_addr_d, fl_data_d};
    end
  end

  // page commit pulse
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_fl_commit <= 1'b0;
    end else begin
      o_fl_commit <= go_cmt;
    end
  end

  // cpu stall for the whole run
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_cpu_hold <= 1'b0;
    end else begin
      o_cpu_hold <= hold_d;
    end
  end
endmodule

//--- fpp_seq_bench.sv
// self-checking bench for the flash page program sequencer
`timescale 1ns/100ps
module fpp_seq_bench;
  import fpp_pkg::*;
  logic i_clk = 0, i_nrst = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, slow = 0, err;
  logic o_pready, o_pslverr, o_ram_rd, o_fl_wr, o_fl_commit, o_cpu_hold, i_fl_ready, i_fl_done;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, o_prdata, rd;
  logic [7:0] i_ram_rdata = 0, o_ram_addr;
  fpp_flash_wr_t o_fl_req;
  int error_cnt = 0, samples_checked = 0;
  fpp_seq i_fpp_seq (.*);
  fpp_flash_model i_fpp_flash_model (.i_clk, .i_slow(slow), .i_fl_wr(o_fl_wr), .i_fl_req(o_fl_req),
    .i_fl_commit(o_fl_commit), .o_fl_ready(i_fl_ready), .o_fl_done(i_fl_done));
  initial forever #5 i_clk = ~i_clk;
  // ram byte is its address xor a marker, so a wrong offset shows
  always @(posedge i_clk) i_ram_rdata <= o_ram_addr ^ 8'h3c;
  task automatic conclude;
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {2'b10, w, a, 24'h0, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      error_cnt++;
      conclude;
    end
    {rd, err} = {o_prdata, o_pslverr};
    {i_psel, i_penable} <= 2'b00;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(a, 1'b0, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    rchk(12'h25c, 8'h00);
    rchk(12'h258, 8'h00);
    apb(12'h300, 1'b1, 8'h11);
    chk({31'h0, err}, 32'h1);
    apb(12'h25c, 1'b1, 8'hf0);
    apb(12'h258, 1'b1, 8'h3f);
    apb(12'h254, 1'b1, 8'hc5);
    apb(12'h250, 1'b1, 8'h5a);
    rchk(12'h260, 8'h00);
    rchk(12'h254, 8'hc0);
    rchk(12'h25c, 8'hf0);
    apb(12'h254, 1'b1, 8'hca);
    slow <= 1'b1; // no watchdog here to clear before the run
    apb(12'h250, 1'b1, 8'h5a);
    repeat (2) @(posedge i_clk);
    rchk(12'h260, 8'h01);
    for (int k = 0; o_cpu_hold !== 1'b0; k++) begin
      @(negedge i_clk);
      if (k > 600) chk(0, 1);
      if (k > 600) conclude;
    end
    // buffer wraps from ram top back to zero
    for (int i = 0; i < 32; i++) chk(i_fpp_flash_model.mem[16'h3fc0 + i], 8'(8'hf0 + i) ^ 8'h3c);
    apb(12'h250, 1'b1, 8'h5a);
    rchk(12'h260, 8'h00);
    conclude;
  end
endmodule
bind fpp_seq fpp_checker i_fpp_checker (.*);
